// ---- acsc_pkg.sv ----
package acsc_pkg;

   // ==========================================================
   // Register map (byte addresses on the APB)
   localparam int ADDR_W = 8;
   localparam int ADDR_LSB = 2;
   localparam logic [7:0] OFF_NCTRL = 8'h00;
   localparam logic [7:0] OFF_NCHAN = 8'h04;
   localparam logic [7:0] OFF_PCTRL = 8'h08;
   localparam logic [7:0] OFF_SRST = 8'h0C;
   localparam logic [7:0] OFF_IRQ_ST = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFF_PRES = 8'h18;
   localparam logic [7:0] OFF_RES0 = 8'h20;
   localparam logic [7:0] RES_SPAN = 8'h20;

   // ==========================================================
   // Field positions
   localparam int NC_START = 0;
   localparam int NC_SCAN = 1;
   localparam int NC_REPEAT = 2;
   localparam int NC_ITM_LO = 3;
   localparam int NC_TRIG_EN = 5;
   localparam int NC_DONE = 6;
   localparam int NC_BUSY = 7;
   localparam int PC_START = 0;
   localparam int PC_CHAN_LO = 1;
   localparam int PC_TRIG_EN = 5;
   localparam int PC_DONE = 6;
   localparam int PC_BUSY = 7;
   localparam int SR_RESET = 0;
   localparam int IRQ_NORMAL = 0;
   localparam int IRQ_PRIO = 1;
   localparam int RES_STORED = 31;
   localparam int RES_OVR = 30;

   // ==========================================================
   // Widths, interval codes and counts
   localparam int DATA_W = 32;
   localparam int RES_W = 10;
   localparam int CH_W = 4;
   localparam int CNT_W = 3;
   localparam int RES_NUM = 8;
   localparam int IRQ_W = 2;
   localparam logic [1:0] ITM_EACH = 2'h0;
   localparam logic [1:0] ITM_FOUR = 2'h1;
   localparam logic [CNT_W-1:0] CNT_EACH_LAST = 3'h0;
   localparam logic [CNT_W-1:0] CNT_FOUR_LAST = 3'h3;
   localparam logic [CNT_W-1:0] CNT_EIGHT_LAST = 3'h7;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_NORMAL, SEQ_PRIO} acsc_seq_type;

   typedef struct packed {
      logic stored;
      logic ovr;
      logic [RES_W-1:0] data;
   } acsc_res_type;

   typedef struct packed {
      acsc_seq_type seq;
      logic scan;
      logic rpt;
      logic [1:0] itm;
      logic ntrig_en;
      logic ndone;
      logic nbusy;
      logic run_rpt;
      logic [CH_W-1:0] nchan;
      logic [CH_W-1:0] pos;
      logic [CNT_W-1:0] cnt;
      logic [CH_W-1:0] pchan;
      logic ptrig_en;
      logic pdone;
      logic pbusy;
      acsc_res_type pres;
      acsc_res_type [RES_NUM-1:0] res;
      logic [IRQ_W-1:0] irq_st;
      logic [IRQ_W-1:0] irq_mask;
      logic irq;
      logic ready;
      logic slverr;
      logic [DATA_W-1:0] rdata;
      logic conv_start;
      logic [CH_W-1:0] conv_chan;
   } acsc_state_type;

   localparam acsc_state_type ST_RESET = '0;

endpackage

// ---- acsc_top.sv ----
`timescale 1ns/10ps
// What this block does
// - Clearing repeat stops after the conversion in progress and drops normal busy.
// - Fixed single: on finish set done, clear busy, raise normal interrupt.
// - Scan single: after the last channel set done, clear busy, interrupt.
// - Fixed repeat keeps busy; done and interrupt at the interval boundary.
// - Interval code 00 each, 01 every four, 10 every eight conversions.
// - Scan repeat: done and interrupt after each pass; busy stays set.
// - Priority finish: store result, set done, clear busy, priority interrupt.
// - Reading a done flag clears it.
// - Each result has stored and overrun flags; valid is stored and no overrun.
// - Repeat and scan bits pick one of the four normal modes.
// - Normal start sets normal busy; priority start keeps normal flags.
// - Priority start suspends normal work, which resumes at the same channel.
// - Start bits begin normal or single fixed-channel priority conversions.
module acsc_top (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [acsc_pkg::ADDR_W-1:0] PADDR_I,
   input wire logic [acsc_pkg::DATA_W-1:0] PWDATA_I,
   output logic [acsc_pkg::DATA_W-1:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Converter core
   input wire logic CONV_DONE_I,
   input wire logic [acsc_pkg::RES_W-1:0] CONV_DATA_I,
   output logic CONV_START_O,
   output logic [acsc_pkg::CH_W-1:0] CONV_CHAN_O,
   // Hardware triggers
   input wire logic NORMAL_TRIG_I,
   input wire logic PRIO_TRIG_I,
   // Interrupt
   output logic IRQ_O
);

   acsc_pkg::acsc_state_type st_q;
   acsc_pkg::acsc_state_type st_d;
   logic wr_en;
   logic rd_cap;

   // ==========================================================
   // Decode helpers
   function automatic logic res_hit(input logic [acsc_pkg::ADDR_W-1:0] a);
      return (a >= acsc_pkg::OFF_RES0) && (a < acsc_pkg::OFF_RES0 + acsc_pkg::RES_SPAN)
         && (a[acsc_pkg::ADDR_LSB-1:0] == '0);
   endfunction

   function automatic logic [acsc_pkg::CNT_W-1:0] res_sel(
         input logic [acsc_pkg::ADDR_W-1:0] a);
      logic [acsc_pkg::ADDR_W-1:0] off;
      off = a - acsc_pkg::OFF_RES0;
      return off[acsc_pkg::ADDR_LSB +: acsc_pkg::CNT_W];
   endfunction

   function automatic logic [acsc_pkg::CH_W-1:0] chan_of(input acsc_pkg::acsc_state_type s);
      return s.scan ? s.pos : s.nchan;
   endfunction

   function automatic logic [acsc_pkg::CNT_W-1:0] last_cnt(input logic [1:0] itm);
      if (itm == acsc_pkg::ITM_EACH) begin
         return acsc_pkg::CNT_EACH_LAST;
      end
      return (itm == acsc_pkg::ITM_FOUR) ? acsc_pkg::CNT_FOUR_LAST : acsc_pkg::CNT_EIGHT_LAST;
   endfunction

   function automatic logic [acsc_pkg::CNT_W-1:0] res_idx(input acsc_pkg::acsc_state_type s);
      logic [acsc_pkg::CH_W-1:0] ch;
      ch = chan_of(s);
      return (s.run_rpt && !s.scan) ? s.cnt : ch[acsc_pkg::CNT_W-1:0];
   endfunction

   // Writes land at the completing edge; reads are captured one edge earlier,
   // so a read-clear cannot swallow an event that arrives in between.
   assign wr_en = PSEL_I & PENABLE_I & st_q.ready & PWRITE_I;
   assign rd_cap = PSEL_I & PENABLE_I & ~st_q.ready & ~PWRITE_I;

   // ==========================================================
   // Next state
   always_comb begin
      logic [acsc_pkg::CNT_W-1:0] ri;
      logic nstart;
      logic pstart;
      logic srst;
      logic last;
      logic fire;
      logic stop;
      logic [acsc_pkg::DATA_W-1:0] rd;
      ri = '0;
      last = 1'b0;
      fire = 1'b0;
      stop = 1'b0;
      rd = '0;
      srst = 1'b0;
      st_d = st_q;
      st_d.conv_start = 1'b0;
      st_d.ready = PSEL_I & PENABLE_I & ~st_q.ready;
      st_d.slverr = 1'b0;
      st_d.rdata = '0;
      nstart = NORMAL_TRIG_I & st_q.ntrig_en;
      pstart = PRIO_TRIG_I & st_q.ptrig_en;

      if (wr_en) begin
         case (PADDR_I)
            acsc_pkg::OFF_NCTRL: begin
               st_d.scan = PWDATA_I[acsc_pkg::NC_SCAN];
               st_d.rpt = PWDATA_I[acsc_pkg::NC_REPEAT];
               st_d.itm = PWDATA_I[acsc_pkg::NC_ITM_LO +: 2];
               st_d.ntrig_en = PWDATA_I[acsc_pkg::NC_TRIG_EN];
               nstart = nstart | PWDATA_I[acsc_pkg::NC_START];
            end
            acsc_pkg::OFF_NCHAN: begin
               st_d.nchan = PWDATA_I[acsc_pkg::CH_W-1:0];
            end
            acsc_pkg::OFF_PCTRL: begin
               st_d.pchan = PWDATA_I[acsc_pkg::PC_CHAN_LO +: acsc_pkg::CH_W];
               st_d.ptrig_en = PWDATA_I[acsc_pkg::PC_TRIG_EN];
               pstart = pstart | PWDATA_I[acsc_pkg::PC_START];
            end
            acsc_pkg::OFF_SRST: begin
               srst = PWDATA_I[acsc_pkg::SR_RESET];
            end
            acsc_pkg::OFF_IRQ_ST: begin
               st_d.irq_st = st_q.irq_st & ~PWDATA_I[acsc_pkg::IRQ_W-1:0];
            end
            acsc_pkg::OFF_IRQ_MASK: begin
               st_d.irq_mask = PWDATA_I[acsc_pkg::IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end

      if (st_d.ready) begin
         case (PADDR_I)
            acsc_pkg::OFF_NCTRL, acsc_pkg::OFF_NCHAN, acsc_pkg::OFF_PCTRL,
            acsc_pkg::OFF_SRST, acsc_pkg::OFF_IRQ_ST, acsc_pkg::OFF_IRQ_MASK,
            acsc_pkg::OFF_PRES: st_d.slverr = 1'b0;
            default: st_d.slverr = !res_hit(PADDR_I);
         endcase
      end

      if (rd_cap) begin
         case (PADDR_I)
            acsc_pkg::OFF_NCTRL: begin
               rd[acsc_pkg::NC_SCAN] = st_q.scan;
               rd[acsc_pkg::NC_REPEAT] = st_q.rpt;
               rd[acsc_pkg::NC_ITM_LO +: 2] = st_q.itm;
               rd[acsc_pkg::NC_TRIG_EN] = st_q.ntrig_en;
               rd[acsc_pkg::NC_DONE] = st_q.ndone;
               rd[acsc_pkg::NC_BUSY] = st_q.nbusy;
               st_d.ndone = 1'b0;
            end
            acsc_pkg::OFF_NCHAN: rd[acsc_pkg::CH_W-1:0] = st_q.nchan;
            acsc_pkg::OFF_PCTRL: begin
               rd[acsc_pkg::PC_CHAN_LO +: acsc_pkg::CH_W] = st_q.pchan;
               rd[acsc_pkg::PC_TRIG_EN] = st_q.ptrig_en;
               rd[acsc_pkg::PC_DONE] = st_q.pdone;
               rd[acsc_pkg::PC_BUSY] = st_q.pbusy;
               st_d.pdone = 1'b0;
            end
            acsc_pkg::OFF_IRQ_ST: rd[acsc_pkg::IRQ_W-1:0] = st_q.irq_st;
            acsc_pkg::OFF_IRQ_MASK: rd[acsc_pkg::IRQ_W-1:0] = st_q.irq_mask;
            acsc_pkg::OFF_PRES: begin
               rd[acsc_pkg::RES_STORED] = st_q.pres.stored;
               rd[acsc_pkg::RES_OVR] = st_q.pres.ovr;
               rd[acsc_pkg::RES_W-1:0] = st_q.pres.data;
               st_d.pres.stored = 1'b0;
               st_d.pres.ovr = 1'b0;
            end
            default: begin
               if (res_hit(PADDR_I)) begin
                  ri = res_sel(PADDR_I);
                  rd[acsc_pkg::RES_STORED] = st_q.res[ri].stored;
                  rd[acsc_pkg::RES_OVR] = st_q.res[ri].ovr;
                  rd[acsc_pkg::RES_W-1:0] = st_q.res[ri].data;
                  st_d.res[ri].stored = 1'b0;
                  st_d.res[ri].ovr = 1'b0;
               end
            end
         endcase
         st_d.rdata = rd;
      end

      // Normal conversion finished
      if (st_q.seq == acsc_pkg::SEQ_NORMAL && CONV_DONE_I) begin
         ri = res_idx(st_q);
         st_d.res[ri].ovr = st_d.res[ri].ovr | st_d.res[ri].stored;
         st_d.res[ri].stored = 1'b1;
         st_d.res[ri].data = CONV_DATA_I;
         last = (st_q.pos == st_q.nchan);
         fire = st_q.scan ? last : (!st_q.run_rpt || st_q.cnt == last_cnt(st_q.itm));
         stop = st_q.run_rpt ? !st_d.rpt : (!st_q.scan || last);
         if (fire) begin
            st_d.ndone = 1'b1;
            st_d.irq_st[acsc_pkg::IRQ_NORMAL] = 1'b1;
         end
         if (st_q.scan) begin
            st_d.pos = last ? '0 : acsc_pkg::CH_W'(st_q.pos + 1'b1);
         end else begin
            st_d.cnt = (st_q.cnt == last_cnt(st_q.itm)) ? '0 : acsc_pkg::CNT_W'(st_q.cnt + 1'b1);
         end
         if (stop) begin
            st_d.nbusy = 1'b0;
            st_d.run_rpt = 1'b0;
            st_d.seq = acsc_pkg::SEQ_IDLE;
         end else begin
            st_d.conv_start = 1'b1;
            st_d.conv_chan = chan_of(st_d);
         end
      end

      // Priority conversion finished
      if (st_q.seq == acsc_pkg::SEQ_PRIO && CONV_DONE_I) begin
         st_d.pres.ovr = st_d.pres.ovr | st_d.pres.stored;
         st_d.pres.stored = 1'b1;
         st_d.pres.data = CONV_DATA_I;
         st_d.pdone = 1'b1;
         st_d.pbusy = 1'b0;
         st_d.irq_st[acsc_pkg::IRQ_PRIO] = 1'b1;
         if (st_q.nbusy) begin
            st_d.seq = acsc_pkg::SEQ_NORMAL;
            st_d.conv_start = 1'b1;
            st_d.conv_chan = chan_of(st_q);
         end else begin
            st_d.seq = acsc_pkg::SEQ_IDLE;
         end
      end

      // A running normal job or a running priority job refuses a new normal start
      if (nstart && !st_q.nbusy && !st_q.pbusy) begin
         st_d.nbusy = 1'b1;
         st_d.run_rpt = st_d.rpt;
         st_d.pos = '0;
         st_d.cnt = '0;
         st_d.seq = acsc_pkg::SEQ_NORMAL;
         st_d.conv_start = 1'b1;
         st_d.conv_chan = chan_of(st_d);
      end

      // Preempts normal work; normal flags are left alone
      if (pstart && !st_q.pbusy) begin
         st_d.pbusy = 1'b1;
         st_d.seq = acsc_pkg::SEQ_PRIO;
         st_d.conv_start = 1'b1;
         st_d.conv_chan = st_d.pchan;
      end

      if (srst) begin
         st_d.seq = acsc_pkg::SEQ_IDLE;
         st_d.nbusy = 1'b0;
         st_d.pbusy = 1'b0;
         st_d.run_rpt = 1'b0;
         st_d.pos = '0;
         st_d.cnt = '0;
         st_d.conv_start = 1'b0;
      end

      st_d.irq = |(st_d.irq_st & st_d.irq_mask);
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_q <= acsc_pkg::ST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign PRDATA_O = st_q.rdata;
   assign PREADY_O = st_q.ready;
   assign PSLVERR_O = st_q.slverr;
   assign CONV_START_O = st_q.conv_start;
   assign CONV_CHAN_O = st_q.conv_chan;
   assign IRQ_O = st_q.irq;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   logic ndone_ev;
   logic srst_w;
   assign ndone_ev = st_q.seq == acsc_pkg::SEQ_NORMAL && CONV_DONE_I;
   assign srst_w = wr_en && PADDR_I == acsc_pkg::OFF_SRST;

   rpt_stop_a: assert property (ndone_ev && st_q.run_rpt && !st_q.rpt && !wr_en
      |=> !st_q.nbusy && st_q.seq == acsc_pkg::SEQ_IDLE)
      else $error("repeat did not stop after clearing");
   fix_single_a: assert property (ndone_ev && !st_q.run_rpt && !st_q.scan && !wr_en
      |=> st_q.ndone && !st_q.nbusy && st_q.irq_st[acsc_pkg::IRQ_NORMAL])
      else $error("fixed single completion flags wrong");
   scan_end_a: assert property (ndone_ev && !st_q.run_rpt && st_q.scan
      && st_q.pos == st_q.nchan && !wr_en |=> st_q.ndone && !st_q.nbusy)
      else $error("scan single completion flags wrong");
   rpt_busy_a: assert property (ndone_ev && st_q.run_rpt && st_q.rpt && !wr_en
      |=> st_q.nbusy ##0 st_q.conv_start)
      else $error("busy dropped in repeat mode");
   itm_four_a: assert property (ndone_ev && st_q.run_rpt && !st_q.scan
      && st_q.itm == acsc_pkg::ITM_FOUR && st_q.cnt != acsc_pkg::CNT_FOUR_LAST
      && !rd_cap && !wr_en |=> st_q.ndone == $past(st_q.ndone) && st_q.cnt == $past(st_q.cnt) + 1)
      else $error("four-conversion interval counted wrong");
   scan_pass_a: assert property (ndone_ev && st_q.run_rpt && st_q.scan && st_q.rpt
      && st_q.pos == st_q.nchan && !wr_en |=> st_q.ndone && st_q.nbusy && st_q.pos == '0)
      else $error("scan pass end handled wrong");
   prio_done_a: assert property (st_q.seq == acsc_pkg::SEQ_PRIO && CONV_DONE_I && !wr_en
      |=> st_q.pres.stored && st_q.pres.data == $past(CONV_DATA_I)
      && st_q.pdone && !st_q.pbusy && st_q.irq_st[acsc_pkg::IRQ_PRIO])
      else $error("priority completion wrong");
   rd_clear_a: assert property (rd_cap && PADDR_I == acsc_pkg::OFF_NCTRL && !CONV_DONE_I
      |=> !st_q.ndone)
      else $error("done not cleared by read");
   start_busy_a: assert property (wr_en && PADDR_I == acsc_pkg::OFF_NCTRL
      && PWDATA_I[acsc_pkg::NC_START] && !st_q.nbusy && !st_q.pbusy
      |=> st_q.nbusy && CONV_START_O)
      else $error("normal start did not set busy");
   prio_resume_a: assert property (st_q.seq == acsc_pkg::SEQ_PRIO && CONV_DONE_I
      && st_q.nbusy && !wr_en |=> CONV_START_O && CONV_CHAN_O == chan_of($past(st_q)))
      else $error("normal work not resumed at same channel");
   prio_ovr_a: assert property (st_q.seq == acsc_pkg::SEQ_PRIO && CONV_DONE_I
      && st_q.pres.stored && !rd_cap |=> st_q.pres.ovr)
      else $error("overrun not flagged");
   irq_out_a: assert property (IRQ_O == |(st_q.irq_st & st_q.irq_mask))
      else $error("interrupt output disagrees with status and mask");

   eight_c: cover property (ndone_ev && st_q.run_rpt && st_q.cnt == acsc_pkg::CNT_EIGHT_LAST);
   preempt_c: cover property (st_q.seq == acsc_pkg::SEQ_NORMAL ##1 st_q.seq == acsc_pkg::SEQ_PRIO);
   stop_c: cover property (ndone_ev && st_q.run_rpt && !st_q.rpt);
   unused_c: cover property (srst_w && st_q.nbusy);

endmodule // acsc_top

// ---- acsc_bench.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
   $display("Error at %0t ns: read %h, expected %h", $time, (got), (exp)); end end

module acsc_bench;
   // ==========================================================
   // Signals and device
   localparam logic [31:0] n_done = 32'h0000_0040;
   localparam logic [31:0] n_busy = 32'h0000_0080;
   localparam logic [31:0] n_flags = 32'h0000_00C0;
   localparam logic [31:0] r_mask = 32'hC000_03FF;
   localparam logic [31:0] r_stored = 32'h8000_0000;
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [acsc_pkg::ADDR_W-1:0] paddr;
   logic [acsc_pkg::DATA_W-1:0] pwdata, prdata, rdat;
   logic conv_done, conv_start, ntrig, ptrig, irq, perr;
   logic [acsc_pkg::RES_W-1:0] conv_data;
   logic [acsc_pkg::CH_W-1:0] conv_chan;
   int fails, n_checks, n, i, c;

   acsc_top dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .CONV_DONE_I(conv_done),
      .CONV_DATA_I(conv_data), .CONV_START_O(conv_start), .CONV_CHAN_O(conv_chan),
      .NORMAL_TRIG_I(ntrig), .PRIO_TRIG_I(ptrig), .IRQ_O(irq));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==========================================================
   // Bus and converter tasks
   task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
      int w;
      w = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= is_wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // The slave decides the wait; only the bound stops a hang here
      do begin
         @(posedge clk);
         w++;
      end while (pready !== 1'b1 && w < 50);
      `CHK(pready, 1'b1)
      rdat = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rdat & m, e)
   endtask

   task automatic wait_start(input logic [3:0] ch);
      int w;
      w = 0;
      do begin
         @(posedge clk);
         w++;
      end while (conv_start !== 1'b1 && w < 200);
      `CHK({conv_start, conv_chan}, {1'b1, ch})
   endtask

   // A bus access here would miss the next one-cycle start pulse
   task automatic done_pulse(input logic [9:0] d);
      @(posedge clk);
      conv_done <= 1'b1;
      conv_data <= d;
      @(posedge clk);
      conv_done <= 1'b0;
   endtask

   task automatic no_start(input int k);
      int seen;
      seen = 0;
      repeat (k) begin
         @(posedge clk);
         if (conv_start === 1'b1) seen++;
      end
      `CHK(seen, 0)
   endtask

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      fails++;
      $display("Error at %0t ns: watchdog expired", $time);
      complete_run;
   end

   // ==========================================================
   // Test sequence
   initial begin
      {rst, psel, penable, pwrite, conv_done, ntrig, ptrig} = 7'h7F & 7'h40;
      paddr = '0;
      pwdata = '0;
      conv_data = '0;
      fails = 0;
      n_checks = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd_chk(acsc_pkg::OFF_NCTRL, 32'hFFFF_FFFF, 32'h0000_0000);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      `CHK(perr, 1'b1)
      // Fixed single by trigger from idle; the trigger is never used to restart
      wr(acsc_pkg::OFF_NCHAN, 32'h0000_0005);
      wr(acsc_pkg::OFF_NCTRL, 32'h0000_0020);
      @(posedge clk) ntrig <= 1'b1;
      @(posedge clk) ntrig <= 1'b0;
      wait_start(4'h5);
      rd_chk(acsc_pkg::OFF_NCTRL, n_flags, n_busy);
      no_start(8);
      done_pulse(10'h155);
      no_start(4);
      rd_chk(acsc_pkg::OFF_NCTRL, n_flags, n_done);
      rd_chk(acsc_pkg::OFF_NCTRL, n_flags, 32'h0000_0000);
      `CHK(irq, 1'b0)
      rd_chk(acsc_pkg::OFF_IRQ_ST, 32'h0000_0003, 32'h0000_0001);
      wr(acsc_pkg::OFF_IRQ_MASK, 32'h0000_0003);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      wr(acsc_pkg::OFF_IRQ_ST, 32'h0000_0001);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      rd_chk(acsc_pkg::OFF_RES0 + 8'h14, r_mask, 32'h8000_0155);
      // Scan single over channels 0 to 2
      wr(acsc_pkg::OFF_NCHAN, 32'h0000_0002);
      wr(acsc_pkg::OFF_NCTRL, 32'h0000_0003);
      for (i = 0; i < 3; i++) begin
         wait_start(4'(i));
         rd_chk(acsc_pkg::OFF_NCTRL, n_flags, n_busy);
         done_pulse(10'(32'h40 + i));
      end
      no_start(4);
      rd_chk(acsc_pkg::OFF_NCTRL, n_flags, n_done);
      for (i = 0; i < 3; i++) begin
         rd_chk(acsc_pkg::OFF_RES0 + 8'(4 * i), r_mask, 32'h8000_0040 + 32'(i));
      end
      // Fixed repeat for each interval code, restarted through soft reset
      for (c = 2; c >= 0; c--) begin
         n = (c == 2) ? 8 : (c == 1) ? 4 : 1;
         wr(acsc_pkg::OFF_SRST, 32'h0000_0001);
         wr(acsc_pkg::OFF_NCHAN, 32'h0000_0003);
         wr(acsc_pkg::OFF_NCTRL, 32'h0000_0005 | (32'(c) << acsc_pkg::NC_ITM_LO));
         for (i = 0; i <= n; i++) begin
            wait_start(4'h3);
            rd_chk(acsc_pkg::OFF_NCTRL, n_flags, (i == n) ? n_done | n_busy : n_busy);
            if (i < n) done_pulse(10'(c * 16 + i));
         end
         for (i = 0; i < n; i++) begin
            rd_chk(acsc_pkg::OFF_RES0 + 8'(4 * i), r_mask, r_stored | (c * 16 + i));
         end
      end
      // Unread result, then stop repeat during a conversion that overruns it
      done_pulse(10'h3A5);
      wait_start(4'h3);
      wr(acsc_pkg::OFF_NCTRL, 32'h0000_0000);
      done_pulse(10'h35A);
      no_start(8);
      rd_chk(acsc_pkg::OFF_NCTRL, n_flags, n_done);
      rd_chk(acsc_pkg::OFF_RES0, r_mask, 32'hC000_035A);
      rd_chk(acsc_pkg::OFF_RES0, 32'hC000_0000, 32'h0000_0000);
      // Priority preempts a scan repeat over channels 0 to 2 and the scan resumes
      wr(acsc_pkg::OFF_NCHAN, 32'h0000_0002);
      wr(acsc_pkg::OFF_PCTRL, 32'h0000_0032);
      wr(acsc_pkg::OFF_NCTRL, 32'h0000_0007);
      wait_start(4'h0);
      done_pulse(10'h001);
      wait_start(4'h1);
      @(posedge clk) ptrig <= 1'b1;
      @(posedge clk) ptrig <= 1'b0;
      wait_start(4'h9);
      rd_chk(acsc_pkg::OFF_PCTRL, 32'h0000_00C0, 32'h0000_0080);
      rd_chk(acsc_pkg::OFF_NCTRL, n_flags, n_busy);
      done_pulse(10'h2AA);
      wait_start(4'h1);
      rd_chk(acsc_pkg::OFF_PCTRL, 32'h0000_00C0, 32'h0000_0040);
      rd_chk(acsc_pkg::OFF_PRES, r_mask, 32'h8000_02AA);
      rd_chk(acsc_pkg::OFF_IRQ_ST, 32'h0000_0002, 32'h0000_0002);
      done_pulse(10'h002);
      wait_start(4'h2);
      done_pulse(10'h003);
      wait_start(4'h0);
      rd_chk(acsc_pkg::OFF_NCTRL, n_flags, n_done | n_busy);
      // Priority start bit from idle, twice, the second overruns the unread result
      wr(acsc_pkg::OFF_SRST, 32'h0000_0001);
      wr(acsc_pkg::OFF_PCTRL, 32'h0000_000D);
      wait_start(4'h6);
      done_pulse(10'h0F0);
      no_start(4);
      rd_chk(acsc_pkg::OFF_PCTRL, 32'h0000_00C0, 32'h0000_0040);
      wr(acsc_pkg::OFF_PCTRL, 32'h0000_000D);
      wait_start(4'h6);
      done_pulse(10'h0F1);
      no_start(4);
      rd_chk(acsc_pkg::OFF_PRES, r_mask, 32'hC000_00F1);
      complete_run;
   end
endmodule // acsc_bench
